//--- hw/camera_controller.sv
// Controller end: sensor clock, reset, preset config shift-in, capture
`timescale 1ns/100ps
`include "isc_consts.svh"
module camera_controller (
  // System
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Link
  sensor_if.ctl link,
  // Capture request
  input wire logic go_i,
  input wire logic [1:0] preset_i,
  input wire logic [15:0] exposure_i,
  // Capture results
  output logic busy_o,
  output logic [7:0] pixel_o,
  output logic pixel_valid_o,
  output logic frame_done_o
);
  logic [2:0] div_r;
  logic sck_r;
  logic rst_n_r;
  logic sdata_r;
  logic load_r;
  logic start_r;
  isc_pkg::ctl_state_t state_r;
  isc_pkg::preset_t preset_r;
  logic [15:0] exp_r;
  logic [3:0] word_r;
  logic [3:0] bit_r;
  logic [1:0] rst_cnt_r;
  logic [13:0] pix_cnt_r;
  logic [7:0] pixel_r;
  logic valid_r;
  logic done_r;
  logic busy_r;

  function automatic logic [7:0] preset_word(input isc_pkg::preset_t p, input logic [3:0] idx,
                                             input logic [15:0] exp);
    logic ro;
    ro = (p == isc_pkg::P_RO_DARK) || (p == isc_pkg::P_RO_NODARK);
    preset_word = 8'h00;
    unique case (idx)
      4'h0: preset_word = ro ? `ISC_W0_RO : `ISC_W0_YPROJ;
      4'h1: preset_word = `ISC_W1;
      4'h2: preset_word = ro ? 8'(`ISC_EXP_NONE) : exp[7:0];
      4'h3: preset_word = ro ? 8'(`ISC_EXP_NONE >> 8) : exp[15:8];
      4'h4:
      begin
        unique case (p)
          isc_pkg::P_RO_DARK: preset_word = `ISC_W4_RO_DARK;
          isc_pkg::P_RO_NODARK: preset_word = `ISC_W4_RO_NODARK;
          default: preset_word = `ISC_W4_YPROJ;
        endcase
      end
      4'h5:
      begin
        unique case (p)
          isc_pkg::P_YPROJ_DARK: preset_word = `ISC_W5_YPROJ_DARK;
          isc_pkg::P_YPROJ_NODARK: preset_word = `ISC_W5_YPROJ_NODARK;
          isc_pkg::P_RO_DARK: preset_word = `ISC_W5_RO_DARK;
          default: preset_word = `ISC_W5_RO_NODARK;
        endcase
      end
      4'h6: preset_word = `ISC_W6;
      4'h7: preset_word = `ISC_W7;
      default: preset_word = 8'h00;
    endcase
  endfunction

  // Divider: sensor clock is this end's own, no second domain
  wire tick = (div_r == `ISC_SCK_HALF - 3'h1);
  wire rise_ev = tick & ~sck_r;
  wire fall_ev = tick & sck_r;
  wire [11:0] frame = {word_r, preset_word(preset_r, word_r, exp_r)};
  wire frame_bit = frame[4'hB - bit_r];

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      div_r <= 3'h0;
      sck_r <= 1'b0;
    end
    else if (ce_i)
    begin
      div_r <= tick ? 3'h0 : div_r + 3'h1;
      if (tick)
        sck_r <= ~sck_r;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_r <= isc_pkg::C_IDLE;
      preset_r <= isc_pkg::P_YPROJ_DARK;
      exp_r <= 16'h0000;
      rst_n_r <= 1'b1;
      sdata_r <= 1'b0;
      load_r <= 1'b0;
      start_r <= 1'b0;
      word_r <= 4'h0;
      bit_r <= 4'h0;
      rst_cnt_r <= 2'h0;
      pix_cnt_r <= 14'h0000;
      pixel_r <= 8'h00;
      valid_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else if (ce_i)
    begin
      valid_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= (state_r != isc_pkg::C_IDLE);
      unique case (state_r)
        isc_pkg::C_IDLE:
          if (go_i && fall_ev)
          begin
            preset_r <= isc_pkg::preset_t'(preset_i);
            exp_r <= exposure_i;
            rst_n_r <= 1'b0;
            rst_cnt_r <= 2'h0;
            word_r <= 4'h0;
            bit_r <= 4'h0;
            state_r <= isc_pkg::C_RST;
          end
        isc_pkg::C_RST:
        begin
          if (rise_ev)
            rst_cnt_r <= rst_cnt_r + 2'h1;
          if (fall_ev && rst_cnt_r == `ISC_RST_RISES)
          begin
            rst_n_r <= 1'b1;
            state_r <= isc_pkg::C_CFG;
          end
        end
        isc_pkg::C_CFG:
          // data changes on fall, sampled on rise
          if (fall_ev)
          begin
            if (bit_r == `ISC_FRAME_BITS)
            begin
              sdata_r <= 1'b0;
              load_r <= 1'b1;
              state_r <= isc_pkg::C_LOAD;
            end
            else
            begin
              sdata_r <= frame_bit;
              bit_r <= bit_r + 4'h1;
            end
          end
        isc_pkg::C_LOAD:
        begin
          if (fall_ev)
            bit_r <= `ISC_LOAD_MARK;
          if (rise_ev && bit_r == `ISC_LOAD_MARK)
          begin
            load_r <= 1'b0;
            bit_r <= 4'h0;
            word_r <= word_r + 4'h1;
            state_r <= (word_r == `ISC_LAST_CFG_WORD) ? isc_pkg::C_START : isc_pkg::C_CFG;
          end
        end
        isc_pkg::C_START:
          if (fall_ev)
          begin
            start_r <= ~start_r;
            if (start_r)
              state_r <= isc_pkg::C_READ;
          end
        isc_pkg::C_READ:
          if (fall_ev && link.read_timing)
          begin
            pixel_r <= link.pixel;
            valid_r <= 1'b1;
            pix_cnt_r <= pix_cnt_r + 14'h0001;
            if (pix_cnt_r == `ISC_LAST_PIXEL)
            begin
              done_r <= 1'b1;
              state_r <= isc_pkg::C_IDLE;
            end
          end
      endcase
    end
  end

  assign link.sensor_clock = sck_r;
  assign link.logic_reset_n = rst_n_r;
  assign link.ser_data = sdata_r;
  assign link.load = load_r;
  assign link.start = start_r;
  assign busy_o = busy_r;
  assign pixel_o = pixel_r;
  assign pixel_valid_o = valid_r;
  assign frame_done_o = done_r;
endmodule

//--- hw/isc_consts.svh
// Constants for the image sensor control sequencer, both ends
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH
`define ISC_WORDS 10
`define ISC_LAST_CFG_WORD 4'h7
`define ISC_FRAME_BITS 4'hC
`define ISC_LOAD_MARK 4'hD
`define ISC_LAST_COL 7'h7F
`define ISC_LAST_PIXEL 14'h3FFF
`define ISC_WORD_EXP_LO 4'h2
`define ISC_WORD_EXP_HI 4'h3
`define ISC_WORD_CAL 4'h4
`define ISC_BIT_CAL 0
`define ISC_WORD_CLAMP 4'h5
`define ISC_BIT_CLAMP_OFF 4
`define ISC_WORD_SCAN 4'h0
`define ISC_BIT_NEG_SCAN 6
`define ISC_RST_RISES 2'h2
`define ISC_SCK_HALF 3'h4
`define ISC_W0_YPROJ 8'h00
`define ISC_W0_RO 8'h80
`define ISC_W1 8'h04
`define ISC_W4_YPROJ 8'hA1
`define ISC_W4_RO_DARK 8'h01
`define ISC_W4_RO_NODARK 8'hA1
`define ISC_W5_YPROJ_DARK 8'h40
`define ISC_W5_YPROJ_NODARK 8'h50
`define ISC_W5_RO_DARK 8'h00
`define ISC_W5_RO_NODARK 8'h10
`define ISC_W6 8'h01
`define ISC_W7 8'h03
`define ISC_EXP_NONE 16'h0000
`endif

//--- hw/isc_pkg.sv
// Types shared by the sensor end and the controller end
package isc_pkg;
  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_PRST = 5'h02,
    D_EXPO = 5'h04,
    D_CAL = 5'h08,
    D_READ = 5'h10
  } dev_state_t;
  typedef enum logic [5:0] {
    C_IDLE = 6'h01,
    C_RST = 6'h02,
    C_CFG = 6'h04,
    C_LOAD = 6'h08,
    C_START = 6'h10,
    C_READ = 6'h20
  } ctl_state_t;
  typedef enum logic [1:0] {
    P_YPROJ_DARK = 2'h0,
    P_YPROJ_NODARK = 2'h1,
    P_RO_DARK = 2'h2,
    P_RO_NODARK = 2'h3
  } preset_t;
endpackage

//--- hw/sensor_if.sv
// Pin-level link between sensor and camera controller
`timescale 1ns/100ps
interface sensor_if;
  logic sensor_clock;
  logic logic_reset_n;
  logic ser_data;
  logic load;
  logic start;
  logic read_timing;
  logic [7:0] pixel;
  modport dev (
    input sensor_clock,
    input logic_reset_n,
    input ser_data,
    input load,
    input start,
    output read_timing,
    output pixel
  );
  modport ctl (
    output sensor_clock,
    output logic_reset_n,
    output ser_data,
    output load,
    output start,
    input read_timing,
    input pixel
  );
endinterface

//--- hw/sensor_device.sv
// Sensor end: config shift/load, exposure sequencing, full 128x128 frame readout
`timescale 1ns/100ps
`include "isc_consts.svh"
module sensor_device (
  // System
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Link
  sensor_if.dev link,
  // Status
  output logic busy_o,
  output logic black_cal_o,
  output logic clamp_off_o
);
  logic sck_q;
  logic [11:0] shift_r;
  logic [7:0] cfg_r [0:`ISC_WORDS-1];
  isc_pkg::dev_state_t state_r;
  logic [15:0] exp_cnt_r;
  logic [6:0] row_r;
  logic [6:0] col_r;
  logic [7:0] seed_r;
  logic [7:0] pix_r;
  logic read_r;
  logic busy_r;
  logic cal_r;
  logic clamp_off_r;

  function automatic logic [7:0] pixel_val(input logic [6:0] row, input logic [6:0] col,
                                           input logic [7:0] seed);
    pixel_val = {1'b0, row} + {1'b0, col} + seed;
  endfunction

  wire rise = link.sensor_clock & ~sck_q;
  wire fall = ~link.sensor_clock & sck_q;
  wire do_reset = rise & ~link.logic_reset_n;
  wire [15:0] exposure = {cfg_r[`ISC_WORD_EXP_HI], cfg_r[`ISC_WORD_EXP_LO]};
  wire cal_en = cfg_r[`ISC_WORD_CAL][`ISC_BIT_CAL];
  wire neg_scan = cfg_r[`ISC_WORD_SCAN][`ISC_BIT_NEG_SCAN];
  wire [6:0] row_phys = neg_scan ? ~row_r : row_r;
  wire last_pix = (row_r == `ISC_LAST_COL) && (col_r == `ISC_LAST_COL);
  wire [3:0] widx = shift_r[11:8];

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      sck_q <= 1'b0;
    else if (ce_i)
      sck_q <= link.sensor_clock;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || (ce_i && do_reset))
      shift_r <= 12'h000;
    else if (ce_i && rise && !link.load)
      shift_r <= {shift_r[10:0], link.ser_data};
  end

  // word latched on fall under load; index in frame
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || (ce_i && do_reset))
    begin
      for (int i = 0; i < `ISC_WORDS; i++)
        cfg_r[i] <= 8'h00;
    end
    else if (ce_i && fall && link.load && (widx < 4'(`ISC_WORDS)))
      cfg_r[widx] <= shift_r[7:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || (ce_i && do_reset))
    begin
      state_r <= isc_pkg::D_IDLE;
      exp_cnt_r <= 16'h0000;
      row_r <= 7'h00;
      col_r <= 7'h00;
      seed_r <= 8'h00;
      pix_r <= 8'h00;
      read_r <= 1'b0;
    end
    else if (ce_i && rise)
    begin
      unique case (state_r)
        isc_pkg::D_IDLE:
        begin
          read_r <= 1'b0;
          row_r <= 7'h00;
          col_r <= 7'h00;
          if (link.start)
            state_r <= (exposure == `ISC_EXP_NONE) ? isc_pkg::D_READ : isc_pkg::D_PRST;
        end
        isc_pkg::D_PRST:
        begin
          // New exposure gives a new image
          seed_r <= seed_r + 8'h01;
          exp_cnt_r <= exposure;
          state_r <= isc_pkg::D_EXPO;
        end
        isc_pkg::D_EXPO:
        begin
          exp_cnt_r <= exp_cnt_r - 16'h0001;
          if (exp_cnt_r == 16'h0001)
            state_r <= cal_en ? isc_pkg::D_CAL : isc_pkg::D_READ;
        end
        isc_pkg::D_CAL:
          state_r <= isc_pkg::D_READ;
        isc_pkg::D_READ:
        begin
          pix_r <= pixel_val(row_phys, col_r, seed_r);
          read_r <= 1'b1;
          col_r <= col_r + 7'h01;
          if (col_r == `ISC_LAST_COL)
            row_r <= row_r + 7'h01;
          if (last_pix)
            state_r <= isc_pkg::D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      busy_r <= 1'b0;
      cal_r <= 1'b0;
      clamp_off_r <= 1'b0;
    end
    else if (ce_i)
    begin
      busy_r <= (state_r != isc_pkg::D_IDLE);
      cal_r <= (state_r == isc_pkg::D_CAL);
      clamp_off_r <= cfg_r[`ISC_WORD_CLAMP][`ISC_BIT_CLAMP_OFF];
    end
  end

  assign link.pixel = pix_r;
  assign link.read_timing = read_r;
  assign busy_o = busy_r;
  assign black_cal_o = cal_r;
  assign clamp_off_o = clamp_off_r;
endmodule

//--- testbench/isc_link_assertions.sv
// Concurrent checks on the sensor link between both ends
`timescale 1ns/100ps
module isc_link_assertions (
  // System
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link
  input wire logic sensor_clock,
  input wire logic logic_reset_n,
  input wire logic ser_data,
  input wire logic load,
  input wire logic start,
  input wire logic read_timing,
  input wire logic [7:0] pixel
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  chk_sck_high_half: assert property ($rose(sensor_clock) |-> sensor_clock [*4] ##1 !sensor_clock)
    else $error("sensor clock high phase wrong");
  chk_sck_low_half: assert property ($fell(sensor_clock) |-> !sensor_clock [*4] ##1 sensor_clock)
    else $error("sensor clock low phase wrong");
  chk_ser_rise_stable: assert property ($rose(sensor_clock) |=> $stable(ser_data))
    else $error("serial data moved at a rise");
  chk_link_reset_span: assert property ($fell(logic_reset_n) |-> ##[1:10] ($rose(sensor_clock)
    && !logic_reset_n) ##[1:10] ($rose(sensor_clock) && !logic_reset_n))
    else $error("link reset not held across two rises");
  chk_load_on_fall: assert property ($rose(load) |-> ##[1:9] ($fell(sensor_clock) && load))
    else $error("load not high at a falling edge");
  chk_start_one_rise: assert property ($rose(start) |-> ##[0:8] ($rose(sensor_clock) && start)
    ##[1:9] !start)
    else $error("start not held across one rise");
  chk_pixel_stands: assert property (read_timing && $changed(pixel) |=> $stable(pixel) [*6])
    else $error("pixel did not stand one period");
  chk_read_on_rise: assert property ($rose(read_timing) |-> sensor_clock && $past(sensor_clock))
    else $error("read timing not raised on a rise");
  chk_read_stands: assert property ($rose(read_timing) |=> read_timing [*7])
    else $error("read timing shorter than a period");
  chk_reset_idle_link: assert property (disable iff (1'b0) rst_i |=> !sensor_clock
    && logic_reset_n && !load && !start && !read_timing)
    else $error("link not idle under reset");

  cover property ($fell(logic_reset_n));
  cover property ($rose(load));
  cover property ($rose(read_timing));
endmodule

//--- testbench/test_image_sensor_control_sequencer.sv
// Self-checking bench: controller and sensor joined over the link
`timescale 1ns/100ps
module test_image_sensor_control_sequencer;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic go_i = 1'b0;
  logic [1:0] preset_i = 2'h0;
  logic [15:0] exposure_i = 16'h0000;
  logic dev_busy, dev_cal, dev_clamp, ctl_busy, pix_valid, frame_done;
  logic [7:0] pix;
  int n_mismatch = 0;
  int compares = 0;

  sensor_if lnk();
  sensor_device sensor_device_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
    .link(lnk), .busy_o(dev_busy), .black_cal_o(dev_cal), .clamp_off_o(dev_clamp));
  camera_controller camera_controller_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
    .link(lnk), .go_i(go_i), .preset_i(preset_i), .exposure_i(exposure_i), .busy_o(ctl_busy),
    .pixel_o(pix), .pixel_valid_o(pix_valid), .frame_done_o(frame_done));
  isc_link_assertions isc_link_assertions_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sensor_clock(lnk.sensor_clock), .logic_reset_n(lnk.logic_reset_n),
    .ser_data(lnk.ser_data), .load(lnk.load), .start(lnk.start),
    .read_timing(lnk.read_timing), .pixel(lnk.pixel));

  always #2.5 clk_sys_i = ~clk_sys_i;

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Also aborts any capture in flight
  task automatic do_reset;
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    go_i <= 1'b0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    cmp("idle link", 16'h1000, {dev_busy, ctl_busy, lnk.sensor_clock, lnk.logic_reset_n,
      lnk.ser_data, lnk.load, lnk.start, lnk.read_timing, lnk.pixel});
  endtask

  // Watch config frames, start delay and the first 130 pixels, then abort
  task automatic capture(input logic [1:0] p, input logic [15:0] e);
    logic [7:0] w [8];
    logic [11:0] sh;
    logic [7:0] p0;
    logic prev, took, cal_seen, rt_seen;
    int nw, k, np, exp_k;
    w = '{(p[1] ? 8'h80 : 8'h00), 8'h04, (p[1] ? 8'h00 : e[7:0]), (p[1] ? 8'h00 : e[15:8]),
      ((p == 2'h2) ? 8'h01 : 8'hA1),
      {1'b0, ~p[1], 1'b0, p[0], 4'h0}, 8'h01, 8'h03};
    exp_k = (p[1] || e == 16'h0000) ? 1 : 3 + int'(e);
    {sh, p0, prev, took, cal_seen, rt_seen} = '0;
    {nw, np} = '0;
    k = -1;
    // Seed counts pixel resets; read-only leaves it at zero
    p0 = {7'h00, ~p[1]};
    do_reset();
    @(posedge clk_sys_i);
    preset_i <= p;
    exposure_i <= e;
    go_i <= 1'b1;
    for (int i = 0; i < 6000 && np < 130; i++)
    begin
      @(negedge clk_sys_i);
      cal_seen |= dev_cal;
      if (!lnk.load)
        took = 1'b0;
      if (lnk.sensor_clock && !prev)
      begin
        if (!lnk.load)
          sh = {sh[10:0], lnk.ser_data};
        if (k >= 0)
          k++;
        if (lnk.start && k < 0)
          k = 0;
      end
      if (!lnk.sensor_clock && prev && lnk.load && !took && nw < 8)
      begin
        cmp("config frame", {4'h0, 4'(nw), w[nw]}, {4'h0, sh});
        nw++;
        took = 1'b1;
      end
      if (lnk.read_timing && !rt_seen)
      begin
        rt_seen = 1'b1;
        cmp("start to readout rises", 16'(exp_k), 16'(k));
        cmp("both busy", 16'h0003, {14'h0, dev_busy, ctl_busy});
      end
      if (pix_valid)
      begin
        cmp("pixel", {8'h00, 8'(int'(p0) + np / 128 + np % 128)}, {8'h00, pix});
        cmp("frame done", {15'h0, np == 16383}, {15'h0, frame_done});
        np++;
      end
      prev = lnk.sensor_clock;
    end
    cmp("words sent", 16'h0008, 16'(nw));
    cmp("pixels seen", 16'd130, 16'(np));
    cmp("calibration step", {15'h0, ~p[1]}, {15'h0, cal_seen});
    cmp("clamp off", {15'h0, p[0]}, {15'h0, dev_clamp});
  endtask

  task automatic scn_yproj;
    capture(2'h0, 16'h0003);
    capture(2'h1, 16'h0005);
  endtask

  task automatic scn_read_only;
    capture(2'h2, 16'h0004);
    capture(2'h3, 16'h0000);
  endtask

  initial
  begin
    scn_yproj();
    scn_read_only();
    do_reset();
    conclude();
  end

  // Four short captures take about 8000 cycles
  initial
  begin
    repeat (40000) @(posedge clk_sys_i);
    n_mismatch++;
    conclude();
  end
endmodule
